/* src/spims_pkg.sv */
/*
  shared constants for the serial peripheral master/slave block:
  field layouts, reset values and configuration limits.
  assumes a single 10 MHz system clock domain.
*/
package spims_pkg;
  localparam int          SPIMS_NUM_CS       = 4;
  localparam int          SPIMS_MAX_BITS     = 16;
  localparam int          SPIMS_LASTX_BIT    = 24;
  localparam logic [7:0]  SPIMS_DIV_RST      = 8'h01;
  localparam logic [3:0]  SPIMS_BITS_RST     = 4'h0;
  localparam logic [4:0]  SPIMS_BITS_BASE    = 5'h08;
  localparam logic [1:0]  SPIMS_CS_NONE      = 2'h0;
  localparam logic [15:0] SPIMS_DATA_RST     = 16'h0000;
  localparam int          SPIMS_SRST_WRITES  = 2;
endpackage

/* src/spims_top.sv */
/*
  serial peripheral master/slave core with fixed chip select, per-chip-select
  baud divisor and word length, and a transfer-size output for the dma channel.
  assumes configuration, data and strobes come from logic on sys_clk; serial
  pins from outside and pass two flip-flops before use.
*/
`timescale 1ns/100ps
module spims_top
  import spims_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // control
  input  wire logic        soft_reset_bit,
  input  wire logic        disable_cmd,
  input  wire logic        enable_cmd,
  input  wire logic        master_select_bit,
  input  wire logic [1:0]  fixed_cs,
  input  wire logic        clock_polarity,
  input  wire logic        clock_phase_select,
  input  wire logic [31:0] cs_divisor_flat,
  input  wire logic [15:0] cs_bits_flat,
  input  wire logic [3:0]  cs_hold_flat,
  // transmit data register write
  input  wire logic        tx_write,
  input  wire logic [31:0] tx_word,
  // serial pins
  input  wire logic        serial_clock_in,
  input  wire logic        slave_select_n_in,
  input  wire logic        serial_data_in,
  output logic             serial_clock_out,
  output logic             serial_data_out,
  output logic [3:0]       chip_select_n,
  // status
  output logic             tx_ready,
  output logic             transmitter_empty_flag,
  output logic             rx_valid,
  output logic [15:0]      rx_data,
  output logic             enabled,
  output logic             transfer_size_half
);
  typedef enum logic [1:0] {SPIMS_IDLE, SPIMS_SHIFT, SPIMS_EXTRA} spims_state_t;
  typedef struct packed {
    spims_state_t st;
    logic        en;
    logic        srst_seen;
    logic [15:0] hold;
    logic        hold_full;
    logic        hold_last;
    logic [15:0] shreg;
    logic [4:0]  bits_left;
    logic [7:0]  divcnt;
    logic        sck;
    logic        last;
    logic [3:0]  csn;
    logic        txrdy;
    logic        txemp;
    logic        rxv;
    logic [15:0] rxd;
    logic        size_half;
    logic        prev_slow;
    logic [2:0]  sclk_sync;
    logic [1:0]  ss_sync;
    logic [1:0]  sd_sync;
    logic        sdo;
  } spims_regs_t;
  spims_regs_t r, n;

  // word length code to bit count
  function automatic logic [4:0] bits_of(input logic [3:0] code);
    logic [4:0] v;
    v = SPIMS_BITS_BASE + {1'b0, code};
    bits_of = (v > 5'(SPIMS_MAX_BITS)) ? 5'(SPIMS_MAX_BITS) : v;
  endfunction

  logic [7:0] cur_div;
  logic [4:0] cur_bits;
  logic       cur_hold;
  logic       all_div_one;
  logic [3:0] msb_idx;
  assign cur_div  = cs_divisor_flat[8*fixed_cs +: 8];
  assign cur_bits = bits_of(cs_bits_flat[4*fixed_cs +: 4]);
  assign cur_hold = cs_hold_flat[fixed_cs];
  assign all_div_one = (cs_divisor_flat == {4{8'h01}});
  // index of the word's msb inside the shift register
  assign msb_idx  = (cur_bits - 5'd1 > 5'd15) ? 4'hF : 4'(cur_bits - 5'd1);

  // next-state logic; slave path samples synchronised pin edges
  always_comb begin
    n = r;
    n.rxv = 1'b0;
    n.sclk_sync = {r.sclk_sync[1], r.sclk_sync[0], serial_clock_in};
    n.ss_sync   = {r.ss_sync[0], slave_select_n_in};
    n.sd_sync   = {r.sd_sync[0], serial_data_in};
    n.size_half = bits_of(cs_bits_flat[3:0]) > 5'd8;
    if (enable_cmd) n.en = 1'b1;
    if (disable_cmd && master_select_bit) n.en = 1'b0;
    if (tx_write && !r.hold_full) begin
      n.hold = tx_word[15:0];
      n.hold_last = tx_word[SPIMS_LASTX_BIT];
      n.hold_full = 1'b1;
      n.txrdy = 1'b0;
      n.txemp = 1'b0;
    end
    case (r.st)
      SPIMS_IDLE: begin
        if (master_select_bit) n.sck = clock_polarity;
        if (r.en && master_select_bit && r.hold_full) begin
          n.shreg = r.hold;
          n.last = r.hold_last;
          n.hold_full = 1'b0;
          // divisor one plus hold leaves ready low after refill
          n.txrdy = !(cur_hold && cur_div == 8'h01);
          n.bits_left = cur_bits;
          n.divcnt = (cur_div == 8'h00) ? 8'h01 : cur_div;
          n.csn = ~(4'b0001 << fixed_cs);
          n.st = SPIMS_SHIFT;
          // fast after slow with cpol 1, clock_phase_select 0 gives a stray pulse unless all divisors are one
          if (clock_polarity && !clock_phase_select && r.prev_slow && cur_div == 8'h01
              && !all_div_one) begin
            n.sck       = ~clock_polarity;
            // the stray pulse also clocks one dummy bit, so one more edge pair
            n.bits_left = cur_bits + 5'd1;
          end
          n.prev_slow = cur_div != 8'h01;
        end else if (!master_select_bit && r.en) begin
          // slave: shift on synchronised rising edges
          if (!r.ss_sync[1] && r.sclk_sync[1] && !r.sclk_sync[2]) begin
            n.shreg = {r.shreg[14:0], r.sd_sync[1]};
            n.bits_left = r.bits_left + 5'd1;
            if (r.bits_left + 5'd1 == cur_bits) begin
              n.rxd = {r.shreg[14:0], r.sd_sync[1]};
              n.rxv = 1'b1;
              n.bits_left = 5'd0;
            end
          end
        end
      end
      SPIMS_SHIFT: begin
        // divided serial clock, two half periods per bit
        if (r.divcnt <= 8'h01) begin
          n.divcnt = (cur_div == 8'h00) ? 8'h01 : cur_div;
          n.sck = ~r.sck;
          if (r.sck != clock_polarity) begin
            n.shreg = {r.shreg[14:0], r.sd_sync[1]};
            n.bits_left = r.bits_left - 5'd1;
            if (r.bits_left == 5'd1) begin
              n.rxd = {r.shreg[14:0], r.sd_sync[1]};
              n.rxv = 1'b1;
              // odd length at divisor one emits one more pulse
              n.st = (cur_div == 8'h01 && cur_bits[0]) ? SPIMS_EXTRA : SPIMS_IDLE;
            end
          end
        end else begin
          n.divcnt = r.divcnt - 8'h01;
        end
        if (n.st == SPIMS_IDLE) begin
          n.txemp = !n.hold_full;
          n.txrdy = !n.hold_full;
          if (!cur_hold || r.last) n.csn = 4'hF;
        end
      end
      SPIMS_EXTRA: begin
        n.sck = ~r.sck;
        if (r.sck != clock_polarity) begin
          n.st = SPIMS_IDLE;
          n.txemp = !n.hold_full;
          n.txrdy = !n.hold_full;
          if (!cur_hold || r.last) n.csn = 4'hF;
        end
      end
      default: n.st = SPIMS_IDLE;
    endcase
    // single write clears state; a second write finishes the reset
    if (soft_reset_bit) begin
      n.srst_seen = 1'b1;
      n.st = SPIMS_IDLE;
      n.en = 1'b0;
      n.hold_full = 1'b0;
      n.csn = 4'hF;
      n.txrdy = 1'b1;
      n.txemp = 1'b1;
      if (r.srst_seen) n.sck = clock_polarity;
    end else if (tx_write) begin
      n.srst_seen = 1'b0;
    end
    // data pin registered so the output leaves a flip-flop
    n.sdo = n.shreg[msb_idx];
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      r <= '0;
      r.st <= SPIMS_IDLE;
      r.csn <= 4'hF;
      r.txrdy <= 1'b1;
      r.txemp <= 1'b1;
      r.hold <= SPIMS_DATA_RST;
      r.sclk_sync <= 3'b000;
      r.ss_sync <= 2'b11;
    end else begin
      r <= n;
    end
  end

  assign serial_clock_out       = r.sck;
  assign serial_data_out        = r.sdo;
  assign chip_select_n          = r.csn;
  assign tx_ready               = r.txrdy;
  assign transmitter_empty_flag = r.txemp;
  assign rx_valid               = r.rxv;
  assign rx_data                = r.rxd;
  assign enabled                = r.en;
  assign transfer_size_half     = r.size_half;

  // checks
  property p_size_cs0;
    @(posedge sys_clk) disable iff (!reset_n)
      1'b1 |=> transfer_size_half == (bits_of($past(cs_bits_flat[3:0])) > 5'd8);
  endproperty
  a_size_cs0: assert property (p_size_cs0) else $error("size not from cs0");
  property p_slave_disable;
    @(posedge sys_clk) disable iff (!reset_n)
      enabled && disable_cmd && !master_select_bit && !soft_reset_bit |=> enabled;
  endproperty
  a_slave_disable: assert property (p_slave_disable) else $error("slave disabled");
  property p_cs_rise_last;
    @(posedge sys_clk) disable iff (!reset_n)
      r.st != SPIMS_IDLE && n.st == SPIMS_IDLE && r.last && !soft_reset_bit |=> chip_select_n == 4'hF;
  endproperty
  a_cs_rise_last: assert property (p_cs_rise_last) else $error("cs held after last");
  property p_extra_odd;
    @(posedge sys_clk) disable iff (!reset_n)
      r.st == SPIMS_EXTRA |-> cur_div == 8'h01 && cur_bits[0];
  endproperty
  a_extra_odd: assert property (p_extra_odd) else $error("extra pulse wrongly");
  property p_even_no_extra;
    @(posedge sys_clk) disable iff (!reset_n)
      r.st == SPIMS_SHIFT && !cur_bits[0] |=> r.st != SPIMS_EXTRA;
  endproperty
  a_even_no_extra: assert property (p_even_no_extra) else $error("extra on even");
  property p_div_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      r.st == SPIMS_SHIFT && r.divcnt > 8'h01 && !soft_reset_bit |=> $stable(serial_clock_out);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("clock not divided");
  property p_ready_low;
    @(posedge sys_clk) disable iff (!reset_n)
      r.st == SPIMS_IDLE && n.st == SPIMS_SHIFT && cur_hold && cur_div == 8'h01 && !soft_reset_bit
      |=> !tx_ready;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("ready rose");
  property p_all_one;
    @(posedge sys_clk) disable iff (!reset_n)
      r.st == SPIMS_IDLE && all_div_one && master_select_bit && !soft_reset_bit && !r.hold_full
      |=> serial_clock_out == $past(clock_polarity);
  endproperty
  a_all_one: assert property (p_all_one) else $error("stray pulse");
  property p_srst_twice;
    @(posedge sys_clk) disable iff (!reset_n)
      soft_reset_bit ##1 soft_reset_bit |=> chip_select_n == 4'hF && !enabled;
  endproperty
  a_srst_twice: assert property (p_srst_twice) else $error("soft reset failed");
  c_xfer: cover property (@(posedge sys_clk) r.st == SPIMS_SHIFT ##1 r.st == SPIMS_IDLE);
  c_extra: cover property (@(posedge sys_clk) r.st == SPIMS_EXTRA);
  c_slave_rx: cover property (@(posedge sys_clk) rx_valid && !master_select_bit);
endmodule

/* test/spims_slave_model.sv */
/*
  behavioural serial slave: shifts its word out msb first and counts
  serial clock pulses. assumes the bench clears the count before each word.
*/
`timescale 1ns/100ps
module spims_slave_model (
  // serial side
  input  wire logic        sck,
  input  wire logic [3:0]  cs_n,
  input  wire logic        mosi,
  output logic             miso,
  // bench side
  input  wire logic        cpol,
  input  wire logic        clr,
  output logic [7:0]       pulses,
  output logic [15:0]      got
);
  logic [15:0] shreg = 16'hC3A5;
  // leading edge for either clock polarity
  wire         lead  = sck ^ cpol;

  // pulses counted anywhere, so a stray one outside the frame shows too;
  // mosi taken on the leading edge, where the master holds it settled
  always @(posedge lead or posedge clr) begin
    if (clr) begin
      pulses <= 8'h00;
      got    <= 16'h0000;
    end else begin
      pulses <= pulses + 8'h01;
      if (!(&cs_n)) got <= {got[14:0], mosi};
    end
  end
  // next bit goes out on the trailing edge, only while selected
  always @(negedge lead) begin
    if (!(&cs_n)) shreg <= {shreg[14:0], shreg[15]};
  end
  // msb stands as soon as selected; released line shows the inverse
  assign miso = (&cs_n) ? ~shreg[15] : shreg[15];
endmodule

/* test/tb.sv */
/*
  self-checking bench for the serial master/slave core.
  assumes a 10 MHz sys_clk and a behavioural slave on the serial pins.
*/
`timescale 1ns/100ps
module tb;
  import spims_pkg::*;
  logic        sys_clk = 0, reset_n = 0, soft_reset_bit = 0, disable_cmd = 0, enable_cmd = 0;
  logic        master_select_bit = 0, clock_polarity = 0, clock_phase_select = 0, tx_write = 0, clr = 0;
  logic [1:0]  fixed_cs = 0;
  logic [31:0] cs_divisor_flat = 32'h0101_0101, tx_word = 0;
  logic [15:0] cs_bits_flat = 0, rx_data;
  logic [3:0]  cs_hold_flat = 0, chip_select_n;
  logic        serial_clock_out, serial_data_out, serial_data_in, tx_ready, transmitter_empty_flag;
  logic        rx_valid, enabled, transfer_size_half;
  logic [7:0]  pulses, rx_seen = 8'h00;
  logic [15:0] got;
  logic        slave_sclk = 0, slave_ss_n = 1, slave_sdi = 0, model_miso;
  int          errors = 0, check_count = 0, k;

  always #50 sys_clk = ~sys_clk;
  // received words counted here, since rx_valid stands one cycle only
  always @(posedge sys_clk) rx_seen <= clr ? 8'h00 : rx_seen + {7'h00, rx_valid};
  // data pin: the serial model in master mode, the bench in slave mode
  assign serial_data_in = master_select_bit ? model_miso : slave_sdi;

  spims_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .soft_reset_bit(soft_reset_bit),
    .disable_cmd(disable_cmd), .enable_cmd(enable_cmd), .master_select_bit(master_select_bit),
    .fixed_cs(fixed_cs), .clock_polarity(clock_polarity), .clock_phase_select(clock_phase_select),
    .cs_divisor_flat(cs_divisor_flat), .cs_bits_flat(cs_bits_flat), .cs_hold_flat(cs_hold_flat),
    .tx_write(tx_write), .tx_word(tx_word), .serial_clock_in(slave_sclk), .slave_select_n_in(slave_ss_n),
    .serial_data_in(serial_data_in), .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
    .chip_select_n(chip_select_n), .tx_ready(tx_ready), .transmitter_empty_flag(transmitter_empty_flag),
    .rx_valid(rx_valid), .rx_data(rx_data), .enabled(enabled), .transfer_size_half(transfer_size_half));
  spims_slave_model u_slave (.sck(serial_clock_out), .cs_n(chip_select_n), .mosi(serial_data_out),
    .miso(model_miso), .cpol(clock_polarity), .clr(clr), .pulses(pulses), .got(got));

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one word: wait ready, strobe, wait two cycles, then wait for empty to rise again
  task automatic xfer(input logic [1:0] cs, input logic [31:0] w);
    int i;
    i = 0;
    while (tx_ready !== 1'b1 && i < 3000) begin tick(); i++; end
    fixed_cs <= cs;
    clr      <= 1'b1;
    tick();
    clr      <= 1'b0;
    tx_write <= 1'b1;
    tx_word  <= w;
    tick();
    tx_write <= 1'b0;
    tick(2);
    #1;
    while (transmitter_empty_flag !== 1'b1 && i < 3000) begin tick(); i++; end
    if (i >= 3000) errors++;
    tick(4);
  endtask
  // slave word: select, then eight bits msb first on an 800 ns link clock
  task automatic slave_word(input logic [7:0] w);
    clr        <= 1'b1;
    slave_ss_n <= 1'b0;
    tick(4);
    clr        <= 1'b0;
    for (int b = 7; b >= 0; b--) begin
      slave_sdi  <= w[b];
      tick(4);
      slave_sclk <= 1'b1;
      tick(4);
      slave_sclk <= 1'b0;
    end
    tick(4);
    slave_ss_n <= 1'b1;
    tick(4);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under 20000 cycles
  initial begin
    #2_000_000;
    errors++;
    finish_test();
  end

  initial begin
    tick(16);
    reset_n <= 1'b1;
    tick(2);
    check({8'h00, serial_clock_out, transmitter_empty_flag, tx_ready, enabled, chip_select_n}, 16'h006F);
    $display("reset test done");
    // master select first, then per-chip-select settings
    master_select_bit <= 1'b1;
    enable_cmd        <= 1'b1;
    tick();
    enable_cmd        <= 1'b0;
    cs_divisor_flat   <= 32'h0101_0102;
    tick();
    xfer(2'h0, 32'h0000_A55A);
    check({8'h00, pulses}, 16'h0008);
    check(got, 16'h005A);
    check({8'h00, rx_data[7:0]}, 16'h00C3);
    check({8'h00, rx_seen}, 16'h0001);
    // every word length at divisor one
    for (k = 0; k < 9; k++) begin
      cs_bits_flat[7:4] <= k[3:0];
      xfer(2'h1, 32'h0000_1234);
      check({8'h00, pulses}, 16'(8 + k + (k % 2)));
    end
    $display("length test done");
    // size output follows chip select zero only
    cs_bits_flat <= 16'h0002;
    fixed_cs     <= 2'h1;
    tick(3);
    check({15'h0000, transfer_size_half}, 16'h0001);
    cs_bits_flat <= 16'h0020;
    tick(3);
    check({15'h0000, transfer_size_half}, 16'h0000);
    cs_bits_flat <= 16'h0000;
    // hold with divisor two, never one
    cs_divisor_flat <= 32'h0101_0202;
    cs_hold_flat    <= 4'h2;
    xfer(2'h1, 32'h0000_0F0F);
    check({12'h000, chip_select_n}, 16'h000D);
    xfer(2'h1, 32'h0100_00F0);
    check({12'h000, chip_select_n}, 16'h000F);
    $display("hold test done");
    // slow then fast with polarity one, phase zero
    cs_hold_flat       <= 4'h0;
    clock_polarity     <= 1'b1;
    clock_phase_select <= 1'b0;
    cs_divisor_flat    <= 32'h0101_0103;
    xfer(2'h0, 32'h0000_00AA);
    check({8'h00, pulses}, 16'h0008);
    xfer(2'h1, 32'h0000_0055);
    check({8'h00, pulses}, 16'h0009);
    // slow word first, then all divisors one: no stray pulse may follow
    xfer(2'h0, 32'h0000_00AA);
    cs_divisor_flat <= 32'h0101_0101;
    xfer(2'h1, 32'h0000_0055);
    check({8'h00, pulses}, 16'h0008);
    $display("mixed divisor test done");
    // slave: disable ignored, double soft reset stops it
    master_select_bit <= 1'b0;
    disable_cmd       <= 1'b1;
    tick();
    disable_cmd       <= 1'b0;
    tick(2);
    check({15'h0000, enabled}, 16'h0001);
    slave_word(8'hB6);
    check({8'h00, rx_data[7:0]}, 16'h00B6);
    check({8'h00, rx_seen}, 16'h0001);
    soft_reset_bit <= 1'b1;
    tick(2);
    soft_reset_bit <= 1'b0;
    tick(2);
    check({14'h0000, enabled, tx_ready}, 16'h0001);
    $display("slave test done");
    finish_test();
  end
endmodule
